// >>> tap_sleep_pkg.sv
/*
  constants shared by the tap, sleep-handover and offset logic:
  register offsets, field positions, reset values and tap states.
  assumes nothing beyond a systemverilog compiler.
*/
package tap_sleep_pkg;

  localparam int          ADDR_W         = 6;
  localparam int          REG_W          = 8;

  localparam logic [5:0]  ADDR_TAP_THR   = 6'h1D;
  localparam logic [5:0]  ADDR_X_TRIM    = 6'h1E;
  localparam logic [5:0]  ADDR_Y_TRIM    = 6'h1F;
  localparam logic [5:0]  ADDR_Z_TRIM    = 6'h20;
  localparam logic [5:0]  ADDR_TAP_DUR   = 6'h21;
  localparam logic [5:0]  ADDR_LATENCY   = 6'h22;
  localparam logic [5:0]  ADDR_WINDOW    = 6'h23;
  localparam logic [5:0]  ADDR_AXIS_CTL  = 6'h2A;
  localparam logic [5:0]  ADDR_STATUS    = 6'h2B;
  localparam logic [5:0]  ADDR_EV_ENABLE = 6'h2E;
  localparam logic [5:0]  ADDR_EV_SOURCE = 6'h30;

  // event enable / event source bit positions
  localparam int          EV_SINGLE      = 6;
  localparam int          EV_DOUBLE      = 5;
  localparam int          EV_ACT         = 4;
  localparam int          EV_INACT       = 3;

  // tap axis control bit positions
  localparam int          AXC_SUPPRESS   = 3;
  localparam int          AXC_X          = 2;
  localparam int          AXC_Z          = 0;

  // motion event status fields
  localparam int          STS_ACT_LO     = 4;
  localparam int          STS_ACT_HI     = 6;
  localparam int          STS_ASLEEP     = 3;
  localparam int          STS_TAP_LO     = 0;
  localparam int          STS_TAP_HI     = 2;

  localparam logic [7:0]  TRIM_RESET     = 8'h00;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [7:0]  CNT_ZERO       = 8'h00;
  localparam logic [7:0]  CNT_ONE        = 8'h01;

  // trim count = 4 output counts, threshold count = 16 output counts
  localparam int          TRIM_SHIFT     = 2;
  localparam int          THR_SHIFT      = 4;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_TAP1    = 6'h02,
    ST_LAT     = 6'h04,
    ST_WIN     = 6'h08,
    ST_TAP2    = 6'h10,
    ST_WAITLOW = 6'h20
  } tap_state_t;

endpackage : tap_sleep_pkg

// >>> offset_adder.sv
/*
  one axis of offset trim: adds the signed trim, weighted four output
  counts per trim count, to each sample and registers the sum.
  assumes samples arrive as single-cycle valid strobes on mclk.
*/
`timescale 1ns/100ps
module offset_adder
  import tap_sleep_pkg::*;
#(
  parameter int SAMPLE_W = 13,
  parameter int OUT_W    = 16
) (
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       sample_valid,
  input  wire logic signed [SAMPLE_W-1:0] sample,
  input  wire logic        [7:0]          trim,
  output logic signed      [OUT_W-1:0]    data_ff
);

  logic signed [OUT_W-1:0] nxt_data;

  // sum wraps at OUT_W; OUT_W leaves headroom above the sample width
  always_comb begin
    nxt_data = OUT_W'(sample) + (OUT_W'($signed(trim)) <<< TRIM_SHIFT);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_ff <= '0;
    end else if (sample_valid) begin
      data_ff <= nxt_data;
    end
  end

endmodule : offset_adder

// >>> tap_sleep_offset_logic.sv
/*
  tap detection, link/autosleep handover and offset trim of a
  three-axis accelerometer, with its register port.
  assumes samples and activity/inactivity strobes come from logic on
  mclk, one sample_valid per undecimated internal sample.
*/
`timescale 1ns/100ps
module tap_sleep_offset_logic
  import tap_sleep_pkg::*;
#(
  parameter int SAMPLE_W = 13,
  parameter int OUT_W    = 16
) (
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       sample_valid,
  input  wire logic signed [SAMPLE_W-1:0] sample_x,
  input  wire logic signed [SAMPLE_W-1:0] sample_y,
  input  wire logic signed [SAMPLE_W-1:0] sample_z,
  input  wire logic                       activity_det,
  input  wire logic                       inactivity_det,
  input  wire logic        [2:0]          act_first_axis,
  input  wire logic                       sleep_en,
  input  wire logic                       auto_sleep_en,
  input  wire logic                       link_en,
  input  wire logic                       int_invert,
  input  wire logic        [ADDR_W-1:0]   reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic        [REG_W-1:0]    reg_wdata,
  output logic             [REG_W-1:0]    reg_rdata_ff,
  output logic signed      [OUT_W-1:0]    data_x_ff,
  output logic signed      [OUT_W-1:0]    data_y_ff,
  output logic signed      [OUT_W-1:0]    data_z_ff,
  output logic                            int_out,
  output logic                            asleep_ff,
  output logic                            act_det_en,
  output logic                            inact_det_en
);

  logic [7:0] thr_ff;
  logic [7:0] x_trim_ff;
  logic [7:0] y_trim_ff;
  logic [7:0] z_trim_ff;
  logic [7:0] dur_ff;
  logic [7:0] lat_ff;
  logic [7:0] win_ff;
  logic [7:0] axc_ff;
  logic [7:0] en_ff;
  logic [7:0] src_ff;
  logic [2:0] act_axis_ff;
  logic [2:0] tap_axis_ff;
  logic [2:0] first_axis_ff;
  logic       watch_act_ff;

  tap_state_t state_ff;
  tap_state_t nxt_state;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic       fire_single;
  logic       fire_double;

  logic [2:0] above_vec;
  logic       above;
  logic       sgl_en;
  logic       dbl_en;
  logic       dbl_ok;
  logic       tap_any_en;
  logic       act_evt;
  logic       inact_evt;
  logic       src_read;
  logic       go_sleep;
  logic [7:0] status;

  // magnitude compare against a threshold in 16-count steps
  function automatic logic over_thr(input logic signed [SAMPLE_W-1:0] s,
                                    input logic [7:0] thr);
    logic [SAMPLE_W:0] mag;
    logic [SAMPLE_W:0] lim;
    mag = s[SAMPLE_W-1] ? (SAMPLE_W+1)'(-s) : (SAMPLE_W+1)'(s);
    lim = (SAMPLE_W+1)'({thr, {THR_SHIFT{1'b0}}});
    over_thr = (mag > lim);
  endfunction : over_thr

  // highest-bit-first one-hot pick, x wins over y over z
  function automatic logic [2:0] first_of(input logic [2:0] v);
    first_of = v[2] ? 3'h4 : (v[1] ? 3'h2 : (v[0] ? 3'h1 : 3'h0));
  endfunction : first_of

  assign above_vec  = {over_thr(sample_x, thr_ff),
                       over_thr(sample_y, thr_ff),
                       over_thr(sample_z, thr_ff)} & axc_ff[AXC_X:AXC_Z];
  assign above      = |above_vec;
  assign sgl_en     = en_ff[EV_SINGLE];
  assign dbl_en     = en_ff[EV_DOUBLE];
  assign tap_any_en = sgl_en | dbl_en;
  // double taps only run with nonzero latency and window
  assign dbl_ok     = dbl_en && (lat_ff != CNT_ZERO) && (win_ff != CNT_ZERO);

  assign src_read = reg_rd && (reg_addr == ADDR_EV_SOURCE);

  // tap sequencer, advanced once per undecimated sample
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    fire_single = 1'b0;
    fire_double = 1'b0;
    if (!tap_any_en) begin
      nxt_state = ST_IDLE;
      nxt_cnt   = CNT_ZERO;
    end else if (sample_valid) begin
      nxt_cnt = cnt_ff + CNT_ONE;
      case (state_ff)
        ST_IDLE: begin
          nxt_cnt = CNT_ZERO;
          if (above) begin
            nxt_state = ST_TAP1;
          end
        end
        ST_TAP1: begin
          if (!above) begin
            nxt_cnt = CNT_ZERO;
            if (dbl_ok) begin
              nxt_state = ST_LAT;
            end else begin
              fire_single = sgl_en;
              nxt_state   = ST_IDLE;
            end
          end else if (cnt_ff >= dur_ff) begin
            nxt_state = ST_WAITLOW;
          end
        end
        ST_LAT: begin
          if (axc_ff[AXC_SUPPRESS] && above) begin
            fire_single = sgl_en;
            nxt_state   = ST_WAITLOW;
          end else if (nxt_cnt >= lat_ff) begin
            nxt_cnt   = CNT_ZERO;
            nxt_state = ST_WIN;
          end
        end
        ST_WIN: begin
          if (above && cnt_ff == CNT_ZERO) begin
            fire_single = sgl_en;
            nxt_state   = ST_WAITLOW;
          end else if (above) begin
            nxt_cnt   = CNT_ZERO;
            nxt_state = ST_TAP2;
          end else if (nxt_cnt >= win_ff) begin
            fire_single = sgl_en;
            nxt_state   = ST_IDLE;
          end
        end
        ST_TAP2: begin
          // the second tap may run past the window end
          if (!above) begin
            fire_single = sgl_en;
            fire_double = 1'b1;
            nxt_state   = ST_IDLE;
          end else if (cnt_ff >= dur_ff) begin
            fire_single = sgl_en;
            nxt_state   = ST_WAITLOW;
          end
        end
        ST_WAITLOW: begin
          // a rejected excursion must end before a new tap can start
          if (!above) begin
            nxt_state = ST_IDLE;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= CNT_ZERO;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      first_axis_ff <= 3'h0;
    end else if (state_ff == ST_IDLE && nxt_state == ST_TAP1) begin
      first_axis_ff <= first_of(above_vec);
    end
  end

  // link and autosleep handover
  assign act_det_en   = en_ff[EV_ACT] && (!link_en || watch_act_ff);
  assign inact_det_en = en_ff[EV_INACT] && (!link_en || !watch_act_ff);
  assign act_evt      = activity_det && act_det_en;
  assign inact_evt    = inactivity_det && inact_det_en;
  // an activity event still unread keeps the block awake
  assign go_sleep     = inact_evt && sleep_en && auto_sleep_en && link_en &&
                        !src_ff[EV_ACT];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      watch_act_ff <= 1'b0;
    end else if (act_evt) begin
      watch_act_ff <= 1'b0;
    end else if (inact_evt) begin
      watch_act_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      asleep_ff <= 1'b0;
    end else if (act_evt || !sleep_en) begin
      asleep_ff <= 1'b0;
    end else if (go_sleep) begin
      asleep_ff <= 1'b1;
    end
  end

  // sticky sources: a set in the read cycle survives the clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      src_ff <= CFG_RESET;
    end else begin
      src_ff <= (src_read ? CFG_RESET : src_ff)
                | (REG_W'(fire_single) << EV_SINGLE)
                | (REG_W'(fire_double) << EV_DOUBLE)
                | (REG_W'(act_evt) << EV_ACT)
                | (REG_W'(inact_evt) << EV_INACT);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tap_axis_ff <= 3'h0;
    end else if (fire_single || fire_double) begin
      tap_axis_ff <= first_axis_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      act_axis_ff <= 3'h0;
    end else if (act_evt) begin
      act_axis_ff <= act_first_axis;
    end
  end

  always_comb begin
    status                         = CFG_RESET;
    status[STS_ACT_HI:STS_ACT_LO]  = act_axis_ff;
    status[STS_ASLEEP]             = asleep_ff;
    status[STS_TAP_HI:STS_TAP_LO]  = tap_axis_ff;
  end

  assign int_out = int_invert ^ (|(src_ff & en_ff));

  // register writes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      thr_ff    <= CFG_RESET;
      x_trim_ff <= TRIM_RESET;
      y_trim_ff <= TRIM_RESET;
      z_trim_ff <= TRIM_RESET;
      dur_ff    <= CFG_RESET;
      lat_ff    <= CFG_RESET;
      win_ff    <= CFG_RESET;
      axc_ff    <= CFG_RESET;
      en_ff     <= CFG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_TAP_THR) begin
        thr_ff <= reg_wdata;
      end else if (reg_addr == ADDR_X_TRIM) begin
        x_trim_ff <= reg_wdata;
      end else if (reg_addr == ADDR_Y_TRIM) begin
        y_trim_ff <= reg_wdata;
      end else if (reg_addr == ADDR_Z_TRIM) begin
        z_trim_ff <= reg_wdata;
      end else if (reg_addr == ADDR_TAP_DUR) begin
        dur_ff <= reg_wdata;
      end else if (reg_addr == ADDR_LATENCY) begin
        lat_ff <= reg_wdata;
      end else if (reg_addr == ADDR_WINDOW) begin
        win_ff <= reg_wdata;
      end else if (reg_addr == ADDR_AXIS_CTL) begin
        axc_ff <= reg_wdata;
      end else if (reg_addr == ADDR_EV_ENABLE) begin
        en_ff <= reg_wdata;
      end
    end
  end

  // register reads, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata_ff <= CFG_RESET;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_TAP_THR) begin
        reg_rdata_ff <= thr_ff;
      end else if (reg_addr == ADDR_X_TRIM) begin
        reg_rdata_ff <= x_trim_ff;
      end else if (reg_addr == ADDR_Y_TRIM) begin
        reg_rdata_ff <= y_trim_ff;
      end else if (reg_addr == ADDR_Z_TRIM) begin
        reg_rdata_ff <= z_trim_ff;
      end else if (reg_addr == ADDR_TAP_DUR) begin
        reg_rdata_ff <= dur_ff;
      end else if (reg_addr == ADDR_LATENCY) begin
        reg_rdata_ff <= lat_ff;
      end else if (reg_addr == ADDR_WINDOW) begin
        reg_rdata_ff <= win_ff;
      end else if (reg_addr == ADDR_AXIS_CTL) begin
        reg_rdata_ff <= axc_ff;
      end else if (reg_addr == ADDR_STATUS) begin
        reg_rdata_ff <= status;
      end else if (reg_addr == ADDR_EV_ENABLE) begin
        reg_rdata_ff <= en_ff;
      end else if (reg_addr == ADDR_EV_SOURCE) begin
        reg_rdata_ff <= src_ff;
      end else begin
        reg_rdata_ff <= CFG_RESET;
      end
    end
  end

  // offset trim per axis
  offset_adder #(.SAMPLE_W(SAMPLE_W), .OUT_W(OUT_W)) u_trim_x (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .sample_valid (sample_valid),
    .sample       (sample_x),
    .trim         (x_trim_ff),
    .data_ff      (data_x_ff)
  );

  offset_adder #(.SAMPLE_W(SAMPLE_W), .OUT_W(OUT_W)) u_trim_y (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .sample_valid (sample_valid),
    .sample       (sample_y),
    .trim         (y_trim_ff),
    .data_ff      (data_y_ff)
  );

  offset_adder #(.SAMPLE_W(SAMPLE_W), .OUT_W(OUT_W)) u_trim_z (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .sample_valid (sample_valid),
    .sample       (sample_z),
    .trim         (z_trim_ff),
    .data_ff      (data_z_ff)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_tap_start: assert property (
    (state_ff == ST_IDLE && sample_valid && above && tap_any_en) |=> state_ff == ST_TAP1)
    else $error("tap did not start above threshold");

  a_dur_reject: assert property (
    (state_ff == ST_TAP1 && sample_valid && tap_any_en && above && cnt_ff >= dur_ff)
    |-> !fire_single && !fire_double ##1 state_ff == ST_WAITLOW)
    else $error("overlong tap was accepted");

  a_latency_enter: assert property (
    (state_ff == ST_TAP1 && sample_valid && tap_any_en && !above && dbl_ok)
    |=> state_ff == ST_LAT && cnt_ff == CNT_ZERO)
    else $error("latency did not follow first tap");

  a_second_tap: assert property (
    (state_ff == ST_WIN && sample_valid && tap_any_en && above && cnt_ff != CNT_ZERO)
    |=> state_ff == ST_TAP2)
    else $error("second tap in window not taken");

  a_single_release: assert property (
    (state_ff == ST_TAP1 && sample_valid && !above && !dbl_ok && sgl_en)
    |=> src_ff[EV_SINGLE] && state_ff == ST_IDLE)
    else $error("single tap not raised on release");

  a_single_defer: assert property (
    (fire_single && dbl_ok) |-> state_ff != ST_TAP1)
    else $error("single tap raised before double verdict");

  a_suppress_kill: assert property (
    (state_ff == ST_LAT && sample_valid && tap_any_en && axc_ff[AXC_SUPPRESS] && above)
    |-> !fire_double ##1 state_ff == ST_WAITLOW)
    else $error("suppress did not cancel double tap");

  a_window_busy: assert property (
    (state_ff == ST_WIN && sample_valid && tap_any_en && above && cnt_ff == CNT_ZERO)
    |=> state_ff == ST_WAITLOW)
    else $error("busy window start not rejected");

  a_tap2_long: assert property (
    (state_ff == ST_TAP2 && sample_valid && tap_any_en && above && cnt_ff >= dur_ff)
    |-> !fire_double ##1 state_ff == ST_WAITLOW)
    else $error("overlong second tap accepted");

  a_no_sleep_pend: assert property (
    $rose(asleep_ff) |-> !$past(src_ff[EV_ACT]) && $past(link_en) && $past(auto_sleep_en))
    else $error("slept with activity pending or without autosleep");

  a_wake_act: assert property (
    act_evt |=> !asleep_ff && src_ff[EV_ACT] && !watch_act_ff)
    else $error("activity did not wake and rearm");

  a_int_level: assert property (
    (|(src_ff & en_ff)) |-> int_out != int_invert)
    else $error("interrupt level wrong for polarity");

endmodule : tap_sleep_offset_logic

// >>> host_model.sv
/*
  host side of the register port: single-byte writes and reads on mclk.
  assumes the block answers a read one cycle after the reg_rd edge.
*/
`timescale 1ns/100ps
module host_model
  import tap_sleep_pkg::*;
(
  input  wire logic              mclk,
  output logic     [ADDR_W-1:0]  reg_addr,
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic     [REG_W-1:0]   reg_wdata
);
  initial begin
    reg_addr  = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = '0;
  end

  // released write data is inverted so a stale byte is never mistaken for a live one
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // reading event_source is how the host clears events
  task automatic rd(input logic [5:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
  endtask : rd
endmodule : host_model

// >>> tb_top.sv
/*
  self-checking bench for tap_sleep_offset_logic; host_model drives the register port.
  assumes a 25 MHz mclk and that read data follows reg_rd by one cycle.
*/
`timescale 1ns/100ps
module tb_top
  import tap_sleep_pkg::*;
;
  logic                mclk = 1'b0;
  logic                sys_rst, sample_valid, activity_det, inactivity_det;
  logic                sleep_en, auto_sleep_en, link_en, int_invert;
  logic signed [12:0]  sample_x, sample_y, sample_z;
  logic        [2:0]   act_first_axis;
  logic        [5:0]   reg_addr;
  logic                reg_wr, reg_rd, rd_seen;
  logic        [7:0]   reg_wdata, reg_rdata_ff;
  logic signed [15:0]  data_x_ff, data_y_ff, data_z_ff;
  logic                int_out, asleep_ff, act_det_en, inact_det_en;
  logic        [7:0]   exp_q[$];
  logic        [7:0]   t[3];
  logic signed [12:0]  s[3];
  int                  error_cnt = 0, compares = 0, cyc = 0;

  tap_sleep_offset_logic tap_sleep_offset_logic_inst (.mclk(mclk), .sys_rst(sys_rst),
    .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
    .sample_z(sample_z), .activity_det(activity_det), .inactivity_det(inactivity_det),
    .act_first_axis(act_first_axis), .sleep_en(sleep_en), .auto_sleep_en(auto_sleep_en),
    .link_en(link_en), .int_invert(int_invert), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .data_x_ff(data_x_ff), .data_y_ff(data_y_ff), .data_z_ff(data_z_ff), .int_out(int_out),
    .asleep_ff(asleep_ff), .act_det_en(act_det_en), .inact_det_en(inact_det_en));
  host_model host_model_inst (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  always #20 mclk = ~mclk;

  task automatic final_report;
    $display("counts: compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (e !== g) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // read data is judged here, one cycle after the read was taken
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
    if (rd_seen === 1'b1) chk("reg_rdata", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata_ff});
    rd_seen <= reg_rd;
  end

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_model_inst.rd(a);
  endtask : rd

  task automatic ticks(input int n, input logic signed [12:0] xv, input logic signed [12:0] yv);
    repeat (n) begin
      @(posedge mclk);
      sample_valid <= 1'b1;
      sample_x     <= xv;
      sample_y     <= yv;
      @(posedge mclk);
      sample_valid <= 1'b0;
    end
    repeat (2) @(posedge mclk);
  endtask : ticks

  task automatic pulse(input logic act);
    @(posedge mclk);
    if (act) activity_det <= 1'b1;
    else inactivity_det <= 1'b1;
    @(posedge mclk);
    activity_det   <= 1'b0;
    inactivity_det <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : pulse

  initial begin
    {sys_rst, rd_seen} = 2'b10;
    {sample_valid, activity_det, inactivity_det, sleep_en} = 4'h0;
    {auto_sleep_en, link_en, int_invert} = 3'h0;
    {sample_x, sample_y, sample_z, act_first_axis} = '0;
    void'($urandom(32'hF665));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) rd(6'(ADDR_X_TRIM + i), 8'h00);
    rd(6'h3F, 8'h00);
    chk("int_out", 16'h0, {15'h0, int_out});
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      t[i] = 8'($urandom);
      s[i] = 13'($urandom_range(3000));
      s[i] = s[i] - 13'sd1500;
      host_model_inst.wr(6'(ADDR_X_TRIM + i), t[i]);
    end
    @(posedge mclk);
    {sample_valid, sample_x, sample_y, sample_z} <= {1'b1, s[0], s[1], s[2]};
    @(posedge mclk);
    sample_valid <= 1'b0;
    #1;
    chk("data_x", 16'(s[0] + 4 * $signed(t[0])), data_x_ff);
    chk("data_y", 16'(s[1] + 4 * $signed(t[1])), data_y_ff);
    chk("data_z", 16'(s[2] + 4 * $signed(t[2])), data_z_ff);
    $display("test offset done");
    host_model_inst.wr(ADDR_TAP_THR, 8'h01);
    host_model_inst.wr(ADDR_TAP_DUR, 8'h03);
    host_model_inst.wr(ADDR_LATENCY, 8'h02);
    host_model_inst.wr(ADDR_WINDOW, 8'h04);
    host_model_inst.wr(ADDR_AXIS_CTL, 8'h04);
    host_model_inst.wr(ADDR_EV_ENABLE, 8'h40);
    ticks(1, 100, 0);
    ticks(1, 0, 0);
    chk("int_out", 16'h1, {15'h0, int_out});
    rd(ADDR_EV_SOURCE, 8'h40);
    rd(ADDR_STATUS, 8'h04);
    ticks(1, 0, 100);
    ticks(1, 0, 0);
    rd(ADDR_EV_SOURCE, 8'h00);
    // five ticks above: the count reaches tap_max_duration while still above
    ticks(5, 100, 0);
    ticks(1, 0, 0);
    rd(ADDR_EV_SOURCE, 8'h00);
    $display("test single tap done");
    host_model_inst.wr(ADDR_EV_ENABLE, 8'h60);
    ticks(1, 100, 0);
    ticks(4, 0, 0);
    ticks(1, 100, 0);
    ticks(6, 0, 0);
    rd(ADDR_EV_SOURCE, 8'h60);
    ticks(1, 100, 0);
    ticks(3, 0, 0);
    ticks(1, 100, 0);
    ticks(2, 0, 0);
    rd(ADDR_EV_SOURCE, 8'h40);
    ticks(1, 100, 0);
    ticks(4, 0, 0);
    ticks(5, 100, 0);
    ticks(1, 0, 0);
    rd(ADDR_EV_SOURCE, 8'h40);
    host_model_inst.wr(ADDR_AXIS_CTL, 8'h0C);
    ticks(1, 100, 0);
    ticks(1, 0, 0);
    ticks(1, 100, 0);
    ticks(8, 0, 0);
    rd(ADDR_EV_SOURCE, 8'h40);
    $display("test double tap done");
    host_model_inst.wr(ADDR_EV_ENABLE, 8'h18);
    {sleep_en, auto_sleep_en, link_en, act_first_axis} <= 6'b111001;
    repeat (2) @(posedge mclk);
    chk("act_en", 16'h0, {15'h0, act_det_en});
    pulse(1'b0);
    chk("asleep", 16'h1, {15'h0, asleep_ff});
    chk("act_en", 16'h1, {15'h0, act_det_en});
    chk("inact_en", 16'h0, {15'h0, inact_det_en});
    rd(ADDR_STATUS, 8'h0C);
    pulse(1'b1);
    chk("asleep", 16'h0, {15'h0, asleep_ff});
    chk("inact_en", 16'h1, {15'h0, inact_det_en});
    // activity still unread, so this inactivity must not send the block to sleep
    pulse(1'b0);
    chk("asleep", 16'h0, {15'h0, asleep_ff});
    rd(ADDR_EV_SOURCE, 8'h18);
    rd(ADDR_STATUS, 8'h14);
    int_invert <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("int_out", 16'h1, {15'h0, int_out});
    $display("test sleep done");
    final_report();
  end
endmodule : tb_top
